// >>> verilog/spcl_pkg.sv
// constants and types shared by the serial port control and status logic
package spcl_pkg;

  // special-register map, page 0x0
  localparam logic [3:0] SFR_PAGE_SPI      = 4'h0;
  localparam logic [7:0] ADDR_SERIAL_CFG   = 8'h84;
  localparam logic [7:0] ADDR_SERIAL_DATA  = 8'h86;
  localparam logic [7:0] ADDR_PORT_CONTROL = 8'hb0;

  // serial_port_control fields
  localparam int BIT_TRANSFER_DONE   = 7;
  localparam int BIT_WRITE_COLLISION = 6;
  localparam int BIT_MODE_FAULT      = 5;
  localparam int BIT_RECEIVE_OVERRUN = 4;
  localparam int BIT_SELECT_MODE_HI  = 3;
  localparam int BIT_SELECT_MODE_LO  = 2;
  localparam int BIT_TX_EMPTY        = 1;
  localparam int BIT_PORT_ENABLE     = 0;

  // configuration register fields
  localparam int BIT_CFG_BUSY        = 7;
  localparam int BIT_CFG_MASTER      = 6;
  localparam int BIT_CFG_SELECTED    = 3;
  localparam int BIT_CFG_SELECT_PIN  = 2;
  localparam int BIT_CFG_SHIFT_EMPTY = 1;
  localparam int BIT_CFG_RX_EMPTY    = 0;

  // select_mode_field encodings
  localparam logic [1:0] SELECT_MODE_3WIRE  = 2'h0;
  localparam logic [1:0] SELECT_MODE_4WIRE  = 2'h1;
  localparam logic [1:0] SELECT_MODE_RESET  = 2'h1;

  // reset values
  localparam logic       TX_EMPTY_RESET     = 1'h1;
  localparam logic       MASTER_RESET       = 1'h0;
  localparam logic [7:0] BYTE_ZERO          = 8'h00;

  // transfer geometry
  localparam logic [3:0] BITS_PER_BYTE      = 4'h8;
  localparam logic [3:0] LAST_BIT_INDEX     = 4'h7;
  localparam int         RX_DEPTH           = 2;

  // master serial clock timing
  localparam int         CLK_PERIOD_NS      = 25;
  localparam int         SCK_HALF_NS        = 100;
  localparam int         SCK_HALF_CYCLES_I  = (SCK_HALF_NS / CLK_PERIOD_NS) < 1 ? 1 : (SCK_HALF_NS / CLK_PERIOD_NS);
  localparam logic [7:0] SCK_HALF_CYCLES    = 8'(SCK_HALF_CYCLES_I);

  typedef enum logic [1:0] {
    ENG_IDLE = 2'b01,
    ENG_RUN  = 2'b10
  } spcl_state_type;

endpackage : spcl_pkg

// >>> verilog/spcl_link_if.sv
// signals between the control logic and the shift engine
`timescale 1ns/10ps
interface spcl_link_if;
  logic       enabled;
  logic       master;
  logic       tick;
  logic       selected;
  logic       sck_rise;
  logic       sck_fall;
  logic       serial_in;
  logic       tx_valid;
  logic [7:0] tx_byte;
  logic       tx_take;
  logic       rx_ready;
  logic       last_bit;
  logic       done;
  logic [7:0] rx_byte;
  logic       busy;
  logic       sck_drive;
  logic       serial_out;

  modport control (output enabled, master, tick, selected, sck_rise, sck_fall, serial_in, tx_valid, tx_byte,
                   rx_ready, input tx_take, last_bit, done, rx_byte, busy, sck_drive, serial_out);
  modport engine  (input enabled, master, tick, selected, sck_rise, sck_fall, serial_in, tx_valid, tx_byte,
                   rx_ready, output tx_take, last_bit, done, rx_byte, busy, sck_drive, serial_out);
endinterface : spcl_link_if

// >>> verilog/spcl_shift_engine.sv
// byte shift engine for master and slave transfers
`timescale 1ns/10ps
module spcl_shift_engine
  import spcl_pkg::*;
(
  input  wire logic         clk,
  input  wire logic         rst,
  spcl_link_if.engine       lk
);

  spcl_state_type state;
  logic [3:0]     bit_cnt;
  logic [7:0]     shreg;
  logic           loaded;

  assign lk.busy = (state == ENG_RUN) || (bit_cnt != 4'h0);

  ////////////////////////////////////////////////////////////////////////////
  always_ff @(posedge clk) begin
    if (rst) begin
      state         <= ENG_IDLE;
      bit_cnt       <= 4'h0;
      shreg         <= BYTE_ZERO;
      loaded        <= 1'b0;
      lk.sck_drive  <= 1'b0;
      lk.serial_out <= 1'b0;
      lk.tx_take    <= 1'b0;
      lk.last_bit   <= 1'b0;
      lk.done       <= 1'b0;
      lk.rx_byte    <= BYTE_ZERO;
    end else begin
      lk.tx_take  <= 1'b0;
      lk.last_bit <= 1'b0;
      lk.done     <= 1'b0;
      if (!lk.enabled) begin
        state        <= ENG_IDLE;
        bit_cnt      <= 4'h0;
        loaded       <= 1'b0;
        lk.sck_drive <= 1'b0;
      end else if (lk.master) begin
        unique case (state)
          ENG_IDLE: begin
            if (lk.tx_valid && lk.rx_ready) begin
              shreg         <= lk.tx_byte;
              lk.serial_out <= lk.tx_byte[7];
              lk.tx_take    <= 1'b1;
              bit_cnt       <= 4'h0;
              state         <= ENG_RUN;
            end
          end
          ENG_RUN: begin
            if (lk.tick) begin
              if (!lk.sck_drive) begin
                lk.sck_drive <= 1'b1;
                bit_cnt      <= bit_cnt + 4'h1;
                lk.last_bit  <= (bit_cnt == LAST_BIT_INDEX);
              end else begin
                // input sampled at the end of the bit: the pin synchroniser outlasts a half period
                lk.sck_drive <= 1'b0;
                shreg        <= {shreg[6:0], lk.serial_in};
                if (bit_cnt == BITS_PER_BYTE) begin
                  lk.done    <= 1'b1;
                  lk.rx_byte <= {shreg[6:0], lk.serial_in};
                  bit_cnt    <= 4'h0;
                  state      <= ENG_IDLE;
                end else begin
                  lk.serial_out <= shreg[6];
                end
              end
            end
          end
        endcase
      end else begin
        state        <= ENG_IDLE;
        lk.sck_drive <= 1'b0;
        if (!lk.selected) begin
          bit_cnt <= 4'h0;
        end else if (lk.sck_rise) begin
          if (bit_cnt == LAST_BIT_INDEX) begin
            lk.last_bit <= 1'b1;
            lk.done     <= 1'b1;
            lk.rx_byte  <= {shreg[6:0], lk.serial_in};
            bit_cnt     <= 4'h0;
            loaded      <= 1'b0;
          end else begin
            bit_cnt <= bit_cnt + 4'h1;
          end
          shreg <= {shreg[6:0], lk.serial_in};
          // next bit leaves right after the sample edge, so synchroniser delay stays inside the bit
          lk.serial_out <= shreg[6];
        end else if (lk.sck_fall) begin
          lk.serial_out <= shreg[7];
        end else if (bit_cnt == 4'h0 && !loaded && lk.tx_valid) begin
          shreg         <= lk.tx_byte;
          lk.serial_out <= lk.tx_byte[7];
          loaded        <= 1'b1;
          lk.tx_take    <= 1'b1;
        end
      end
    end
  end

endmodule : spcl_shift_engine

// >>> verilog/spcl_control_status.sv
// control register, status flags, buffers and pins of one serial port
`timescale 1ns/10ps
module spcl_control_status
  import spcl_pkg::*;
(
  input  wire logic       clk,
  input  wire logic       rst,
  input  wire logic [3:0] sfr_page,
  input  wire logic [7:0] sfr_addr,
  input  wire logic       sfr_wr,
  input  wire logic [7:0] sfr_wdata,
  input  wire logic       sfr_bit_wr,
  input  wire logic [2:0] sfr_bit_sel,
  input  wire logic       sfr_bit_val,
  input  wire logic       sfr_rd,
  output logic      [7:0] sfr_rdata,
  input  wire logic       int_enable,
  output logic            irq_request,
  input  wire logic       sck_in,
  output logic            sck_out,
  output logic            sck_oe,
  input  wire logic       mosi_in,
  output logic            mosi_out,
  output logic            mosi_oe,
  input  wire logic       miso_in,
  output logic            miso_out,
  output logic            miso_oe,
  input  wire logic       slave_select_line_in,
  output logic            slave_select_line_out,
  output logic            slave_select_line_oe
);

  localparam int NPIN = 4;
  localparam int PIN_SCK = 0;
  localparam int PIN_MOSI = 1;
  localparam int PIN_MISO = 2;
  localparam int PIN_SEL = 3;

  spcl_link_if lk ();

  logic       transfer_done_flag;
  logic       write_collision_flag;
  logic       mode_fault_flag;
  logic       receive_overrun_flag;
  logic [1:0] select_mode_field;
  logic       transmit_buffer_empty;
  logic       port_enable;
  logic       master_enable;
  logic [7:0] tx_buf;
  logic [7:0] div_cnt;
  logic       sck_prev;
  logic [NPIN-1:0] pin_raw;
  logic [NPIN-1:0] pin_val;
  logic [7:0] rx_mem [RX_DEPTH];
  logic       rx_wptr;
  logic       rx_rptr;
  logic [1:0] rx_count;
  logic       rx_push_valid;
  logic       rx_push_ready;
  logic       rx_pop_valid;
  logic       rx_pop_ready;
  logic       hit_page;
  logic       wr_ctrl;
  logic       bit_ctrl;
  logic       wr_data;
  logic       rd_data;
  logic [7:0] ctrl_image;
  logic [7:0] cfg_image;
  logic       four_wire;
  logic       single_master;

  ////////////////////////////////////////////////////////////////////////////
  // register decode
  function automatic logic hit(input logic [7:0] a, input logic [7:0] want);
    return a == want;
  endfunction : hit

  function automatic logic next_bit(input logic cur, input logic [2:0] pos, input logic set_ev);
    logic v;
    v = cur;
    if (wr_ctrl) begin
      v = sfr_wdata[pos];
    end else if (bit_ctrl && sfr_bit_sel == pos) begin
      v = sfr_bit_val;
    end
    return v | set_ev;
  endfunction : next_bit

  assign hit_page  = (sfr_page == SFR_PAGE_SPI);
  assign wr_ctrl   = hit_page && sfr_wr && hit(sfr_addr, ADDR_PORT_CONTROL);
  assign bit_ctrl  = hit_page && sfr_bit_wr && hit(sfr_addr, ADDR_PORT_CONTROL);
  assign wr_data   = hit_page && sfr_wr && hit(sfr_addr, ADDR_SERIAL_DATA);
  assign rd_data   = hit_page && sfr_rd && hit(sfr_addr, ADDR_SERIAL_DATA);
  assign four_wire = (select_mode_field == SELECT_MODE_4WIRE);
  assign single_master = select_mode_field[1];

  assign ctrl_image = {transfer_done_flag, write_collision_flag, mode_fault_flag, receive_overrun_flag,
                       select_mode_field, transmit_buffer_empty, port_enable};
  assign cfg_image  = {lk.busy, master_enable, 2'h0, !pin_val[PIN_SEL], pin_raw[PIN_SEL],
                       !lk.busy || master_enable, !rx_pop_valid || master_enable};

  ////////////////////////////////////////////////////////////////////////////
  // pin synchronisers: a change counts once stages two and three agree
  genvar gi;
  assign pin_raw = {slave_select_line_in, miso_in, mosi_in, sck_in};
  generate
    for (gi = 0; gi < NPIN; gi++) begin : g_sync
      logic [2:0] stage;
      always_ff @(posedge clk) begin
        if (rst) begin
          stage        <= (gi == PIN_SEL) ? 3'h7 : 3'h0;
          pin_val[gi]  <= (gi == PIN_SEL) ? 1'b1 : 1'b0;
        end else begin
          stage <= {stage[1:0], pin_raw[gi]};
          if (stage[1] == stage[2]) begin
            pin_val[gi] <= stage[2];
          end
        end
      end
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////
  // serial clock edges and master rate divider
  always_ff @(posedge clk) begin
    if (rst) begin
      sck_prev <= 1'b0;
    end else begin
      sck_prev <= pin_val[PIN_SCK];
    end
  end

  always_ff @(posedge clk) begin
    if (rst || !lk.busy) begin
      div_cnt <= 8'h0;
      lk.tick <= 1'b0;
    end else if (div_cnt == SCK_HALF_CYCLES - 8'h1) begin
      div_cnt <= 8'h0;
      lk.tick <= 1'b1;
    end else begin
      div_cnt <= div_cnt + 8'h1;
      lk.tick <= 1'b0;
    end
  end

  assign lk.enabled   = port_enable;
  assign lk.master    = master_enable;
  assign lk.sck_rise  = pin_val[PIN_SCK] && !sck_prev;
  assign lk.sck_fall  = !pin_val[PIN_SCK] && sck_prev;
  assign lk.serial_in = master_enable ? pin_val[PIN_MISO] : pin_val[PIN_MOSI];
  assign lk.selected  = (select_mode_field == SELECT_MODE_3WIRE) || !pin_val[PIN_SEL];
  assign lk.tx_valid  = !transmit_buffer_empty;
  assign lk.tx_byte   = tx_buf;
  assign lk.rx_ready  = rx_push_ready;

  spcl_shift_engine u_engine (
    .clk (clk),
    .rst (rst),
    .lk  (lk)
  );

  ////////////////////////////////////////////////////////////////////////////
  // two-entry receive buffer
  assign rx_push_valid = lk.done;
  assign rx_push_ready = (rx_count != 2'(RX_DEPTH));
  assign rx_pop_valid  = (rx_count != 2'h0);
  assign rx_pop_ready  = rd_data;

  always_ff @(posedge clk) begin
    if (rst) begin
      rx_wptr  <= 1'b0;
      rx_rptr  <= 1'b0;
      rx_count <= 2'h0;
      rx_mem   <= '{default: BYTE_ZERO};
    end else begin
      if (rx_push_valid && rx_push_ready) begin
        rx_mem[rx_wptr] <= lk.rx_byte;
        rx_wptr         <= !rx_wptr;
      end
      if (rx_pop_valid && rx_pop_ready) begin
        rx_rptr <= !rx_rptr;
      end
      rx_count <= rx_count + 2'(rx_push_valid && rx_push_ready) - 2'(rx_pop_valid && rx_pop_ready);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // event flags: hardware set wins over a software clear
  always_ff @(posedge clk) begin
    if (rst) begin
      transfer_done_flag   <= 1'b0;
      write_collision_flag <= 1'b0;
      mode_fault_flag      <= 1'b0;
      receive_overrun_flag <= 1'b0;
    end else begin
      transfer_done_flag   <= next_bit(transfer_done_flag, 3'(BIT_TRANSFER_DONE),
                                       port_enable && lk.done);
      write_collision_flag <= next_bit(write_collision_flag, 3'(BIT_WRITE_COLLISION),
                                       port_enable && wr_data && !transmit_buffer_empty);
      mode_fault_flag      <= next_bit(mode_fault_flag, 3'(BIT_MODE_FAULT),
                                       port_enable && master_enable && four_wire && !pin_val[PIN_SEL]);
      receive_overrun_flag <= next_bit(receive_overrun_flag, 3'(BIT_RECEIVE_OVERRUN),
                                       port_enable && !master_enable && lk.last_bit && !rx_push_ready);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // control bits and configuration
  always_ff @(posedge clk) begin
    if (rst) begin
      select_mode_field <= SELECT_MODE_RESET;
      port_enable       <= 1'b0;
      master_enable     <= MASTER_RESET;
    end else begin
      select_mode_field <= {next_bit(select_mode_field[1], 3'(BIT_SELECT_MODE_HI), 1'b0),
                            next_bit(select_mode_field[0], 3'(BIT_SELECT_MODE_LO), 1'b0)};
      port_enable       <= next_bit(port_enable, 3'(BIT_PORT_ENABLE), 1'b0);
      if (hit_page && sfr_wr && hit(sfr_addr, ADDR_SERIAL_CFG)) begin
        master_enable <= sfr_wdata[BIT_CFG_MASTER];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // transmit buffer
  always_ff @(posedge clk) begin
    if (rst) begin
      transmit_buffer_empty <= TX_EMPTY_RESET;
      tx_buf                <= BYTE_ZERO;
    end else if (wr_data && transmit_buffer_empty) begin
      tx_buf                <= sfr_wdata;
      transmit_buffer_empty <= 1'b0;
    end else if (lk.tx_take) begin
      transmit_buffer_empty <= 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // read data and interrupt request
  always_ff @(posedge clk) begin
    if (rst) begin
      sfr_rdata   <= BYTE_ZERO;
      irq_request <= 1'b0;
    end else begin
      irq_request <= int_enable && (transfer_done_flag || write_collision_flag ||
                                    mode_fault_flag || receive_overrun_flag);
      if (sfr_rd && hit_page && hit(sfr_addr, ADDR_PORT_CONTROL)) begin
        sfr_rdata <= ctrl_image;
      end else if (sfr_rd && hit_page && hit(sfr_addr, ADDR_SERIAL_CFG)) begin
        sfr_rdata <= cfg_image;
      end else if (rd_data) begin
        sfr_rdata <= rx_pop_valid ? rx_mem[rx_rptr] : BYTE_ZERO;
      end else if (sfr_rd) begin
        sfr_rdata <= BYTE_ZERO;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // pin drivers
  always_ff @(posedge clk) begin
    if (rst) begin
      sck_out               <= 1'b0;
      sck_oe                <= 1'b0;
      mosi_out              <= 1'b0;
      mosi_oe               <= 1'b0;
      miso_out              <= 1'b0;
      miso_oe               <= 1'b0;
      slave_select_line_out <= 1'b1;
      slave_select_line_oe  <= 1'b0;
    end else begin
      sck_out               <= lk.sck_drive;
      sck_oe                <= port_enable && master_enable;
      mosi_out              <= lk.serial_out;
      mosi_oe               <= port_enable && master_enable;
      miso_out              <= lk.serial_out;
      miso_oe               <= port_enable && !master_enable && lk.selected;
      slave_select_line_out <= select_mode_field[0];
      slave_select_line_oe  <= port_enable && single_master;
    end
  end

endmodule : spcl_control_status

// >>> verif/spcl_props.sv
// assertions on the serial port control pins and register bus
`timescale 1ns/10ps
module spcl_props
  import spcl_pkg::*;
(
  input wire logic       clk,
  input wire logic       rst,
  input wire logic [3:0] sfr_page,
  input wire logic [7:0] sfr_addr,
  input wire logic       sfr_wr,
  input wire logic [7:0] sfr_wdata,
  input wire logic       sfr_bit_wr,
  input wire logic [2:0] sfr_bit_sel,
  input wire logic       sfr_bit_val,
  input wire logic       sfr_rd,
  input wire logic [7:0] sfr_rdata,
  input wire logic       int_enable,
  input wire logic       irq_request,
  input wire logic       sck_oe,
  input wire logic       mosi_oe,
  input wire logic       miso_oe,
  input wire logic       slave_select_line_out,
  input wire logic       slave_select_line_oe
);
  logic [1:0] mode_q;
  logic       en_q;
  logic       master_q;
  wire        pg = sfr_page == SFR_PAGE_SPI;
  ////////////////////////////////////////////////////////////////
  // shadow of the software-written mode bits
  always_ff @(posedge clk) begin
    if (rst) begin
      mode_q <= SELECT_MODE_RESET;
      en_q <= 1'b0;
      master_q <= MASTER_RESET;
    end else if (sfr_wr && pg && sfr_addr == ADDR_PORT_CONTROL) begin
      mode_q <= sfr_wdata[3:2];
      en_q <= sfr_wdata[0];
    end else if (sfr_wr && pg && sfr_addr == ADDR_SERIAL_CFG) begin
      master_q <= sfr_wdata[6];
    end else if (sfr_bit_wr && pg && sfr_addr == ADDR_PORT_CONTROL) begin
      if (sfr_bit_sel == 3'h0) en_q <= sfr_bit_val;
      if (sfr_bit_sel == 3'h2) mode_q[0] <= sfr_bit_val;
      if (sfr_bit_sel == 3'h3) mode_q[1] <= sfr_bit_val;
    end
  end
  ////////////////////////////////////////////////////////////////
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  sequence s_foreign_read;
    sfr_rd && !pg;
  endsequence
  sequence s_single_master;
    en_q && mode_q[1];
  endsequence
  property p_ss_level;
    s_single_master |=> slave_select_line_oe && slave_select_line_out == $past(mode_q[0]);
  endproperty
  a_ss_level: assert property (p_ss_level) else $error("select output level wrong");
  property p_ss_off;
    (!en_q || !mode_q[1]) |=> !slave_select_line_oe;
  endproperty
  a_ss_off: assert property (p_ss_off) else $error("select driven outside single master");
  property p_irq_off;
    !int_enable |=> !irq_request;
  endproperty
  a_irq_off: assert property (p_irq_off) else $error("request while interrupts off");
  property p_foreign_read;
    s_foreign_read |=> sfr_rdata == BYTE_ZERO;
  endproperty
  a_foreign_read: assert property (p_foreign_read) else $error("other page read not zero");
  property p_rdata_hold;
    !sfr_rd |=> $stable(sfr_rdata);
  endproperty
  a_rdata_hold: assert property (p_rdata_hold) else $error("read data moved without read");
  property p_disabled_quiet;
    !en_q |=> !sck_oe && !mosi_oe && !miso_oe;
  endproperty
  a_disabled_quiet: assert property (p_disabled_quiet) else $error("disabled port drives pins");
  property p_master_drive;
    en_q && master_q |=> sck_oe && mosi_oe;
  endproperty
  a_master_drive: assert property (p_master_drive) else $error("master not driving clock");
  property p_slave_quiet;
    en_q && !master_q |=> !sck_oe && !mosi_oe;
  endproperty
  a_slave_quiet: assert property (p_slave_quiet) else $error("slave drives clock");
endmodule : spcl_props

// >>> verif/spcl_far_device.sv
// far side serial device, master or slave, clock idle low, msb first
`timescale 1ns/10ps
module spcl_far_device (
  input wire logic sck_pin,
  input wire logic mosi_pin,
  input wire logic miso_pin,
  output logic     sck_drv,
  output logic     mosi_drv,
  output logic     miso_drv,
  output logic     select_drv
);
  logic [7:0] reply;
  logic [7:0] got;
  initial begin
    sck_drv = 1'b0;
    mosi_drv = 1'b0;
    select_drv = 1'b1;
    reply = 8'h00;
    got = 8'h00;
  end
  assign miso_drv = reply[7];
  always @(posedge sck_pin) got = {got[6:0], mosi_pin};
  always @(negedge sck_pin) reply = {reply[6:0], ~reply[0]};
  task automatic master_xfer(input logic [7:0] tx, output logic [7:0] rx);
    #7 select_drv = 1'b0;
    #200;
    for (int i = 7; i >= 0; i--) begin
      mosi_drv = tx[i];
      #100 sck_drv = 1'b1;
      rx = {rx[6:0], miso_pin};
      #100 sck_drv = 1'b0;
    end
    #200 select_drv = 1'b1;
    mosi_drv = ~mosi_drv;
  endtask : master_xfer
endmodule : spcl_far_device

// >>> verif/test_spcl_control_status.sv
// self-checking bench for the serial port control and status logic
`timescale 1ns/10ps
module test_spcl_control_status
  import spcl_pkg::*;
;
  logic       clk = 1'b0;
  logic       rst = 1'b1;
  logic [3:0] sfr_page = 4'h0;
  logic [7:0] sfr_addr = 8'h00;
  logic       sfr_wr = 1'b0;
  logic [7:0] sfr_wdata = 8'h00;
  logic       sfr_bit_wr = 1'b0;
  logic [2:0] sfr_bit_sel = 3'h0;
  logic       sfr_bit_val = 1'b0;
  logic       sfr_rd = 1'b0;
  logic       int_enable = 1'b1;
  logic [7:0] sfr_rdata;
  logic       irq_request, sck_out, sck_oe, mosi_out, mosi_oe, miso_out, miso_oe;
  logic       slave_select_line_out, slave_select_line_oe;
  logic       sck_drv, mosi_drv, miso_drv, select_drv;
  wire logic  sck_in = sck_oe ? sck_out : sck_drv;
  wire logic  mosi_in = mosi_oe ? mosi_out : mosi_drv;
  wire logic  miso_in = miso_oe ? miso_out : miso_drv;
  wire logic  slave_select_line_in = slave_select_line_oe ? slave_select_line_out : select_drv;
  int         failures = 0;
  int         comparisons = 0;
  int unsigned seed;
  logic [7:0] v, d, e, r;
  logic [7:0] b [3];
  always #12.5 clk = ~clk;
  spcl_control_status dut_u (.*);
  spcl_far_device far_u (
    .sck_pin    (sck_in),
    .mosi_pin   (mosi_in),
    .miso_pin   (miso_in),
    .sck_drv    (sck_drv),
    .mosi_drv   (mosi_drv),
    .miso_drv   (miso_drv),
    .select_drv (select_drv)
  );
  ////////////////////////////////////////////////////////////////
  function automatic logic [7:0] ctl(input logic [3:0] f, input logic [1:0] m, input logic t, input logic en);
    return {f, m, t, en};
  endfunction : ctl
  task automatic chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
    comparisons++;
    if (seen !== exp) begin
      failures++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk
  task automatic wr(input logic [7:0] a, input logic [7:0] dat);
    @(posedge clk);
    sfr_addr <= a;
    sfr_wdata <= dat;
    sfr_wr <= 1'b1;
    @(posedge clk);
    sfr_wr <= 1'b0;
  endtask : wr
  task automatic bwr(input logic [2:0] s, input logic bv);
    @(posedge clk);
    sfr_addr <= ADDR_PORT_CONTROL;
    sfr_bit_sel <= s;
    sfr_bit_val <= bv;
    sfr_bit_wr <= 1'b1;
    @(posedge clk);
    sfr_bit_wr <= 1'b0;
  endtask : bwr
  task automatic rd(input logic [7:0] a, output logic [7:0] dat);
    @(posedge clk);
    sfr_addr <= a;
    sfr_rd <= 1'b1;
    @(posedge clk);
    sfr_rd <= 1'b0;
    #1 dat = sfr_rdata;
  endtask : rd
  task automatic wrap_up;
    if (failures == 0 && comparisons > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : wrap_up
  ////////////////////////////////////////////////////////////////
  initial begin
    #2000000;
    failures++;
    wrap_up();
  end
  initial begin
    seed = $urandom(98);
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    rd(ADDR_PORT_CONTROL, v);
    chk("ctl_reset", v, ctl(4'h0, SELECT_MODE_RESET, 1'b1, 1'b0));
    rd(ADDR_SERIAL_CFG, v);
    chk("cfg_reset", v, 8'h07);
    sfr_page <= 4'h1;
    rd(ADDR_PORT_CONTROL, v);
    chk("other_page", v, BYTE_ZERO);
    sfr_page <= 4'h0;
    bwr(3'h0, 1'b1);
    bwr(3'h1, 1'b0);
    rd(ADDR_PORT_CONTROL, v);
    chk("bit_write", v, ctl(4'h0, 2'h1, 1'b1, 1'b1));
    for (int m = 0; m < 4; m++) begin
      wr(ADDR_PORT_CONTROL, ctl(4'h0, m[1:0], 1'b0, 1'b1));
      repeat (2) @(posedge clk);
      #1 chk("ss_oe", {7'h0, slave_select_line_oe}, {7'h0, m[1]});
      if (m > 1) chk("ss_out", {7'h0, slave_select_line_out}, {7'h0, m[0]});
    end
    // master transfers, first one with a colliding second write
    wr(ADDR_SERIAL_CFG, 8'h40);
    wr(ADDR_PORT_CONTROL, ctl(4'h0, SELECT_MODE_3WIRE, 1'b0, 1'b1));
    for (int i = 0; i < 4; i++) begin
      d = $urandom;
      e = $urandom;
      far_u.reply = e;
      @(posedge clk);
      sfr_addr <= ADDR_SERIAL_DATA;
      sfr_wdata <= d;
      sfr_wr <= 1'b1;
      @(posedge clk);
      if (i == 0) sfr_wdata <= ~d;
      else sfr_wr <= 1'b0;
      @(posedge clk);
      sfr_wr <= 1'b0;
      v = 8'h00;
      for (int k = 0; k < 60 && !v[7]; k++) rd(ADDR_PORT_CONTROL, v);
      chk("ctl_done", v, ctl({1'b1, i == 0, 2'h0}, 2'h0, 1'b1, 1'b1));
      @(posedge clk);
      #1 chk("irq", {7'h0, irq_request}, 8'h01);
      chk("far_got", far_u.got, d);
      rd(ADDR_SERIAL_DATA, v);
      chk("rx_data", v, e);
      repeat (20) @(posedge clk);
      rd(ADDR_PORT_CONTROL, v);
      chk("flags_kept", v[7:6], {1'b1, i == 0});
      wr(ADDR_PORT_CONTROL, ctl(4'h0, 2'h0, 1'b0, 1'b1));
      rd(ADDR_PORT_CONTROL, v);
      chk("flags_clear", v, ctl(4'h0, 2'h0, 1'b1, 1'b1));
    end
    far_u.select_drv = 1'b0;
    repeat (10) @(posedge clk);
    rd(ADDR_PORT_CONTROL, v);
    chk("no_fault_3w", v, ctl(4'h0, 2'h0, 1'b1, 1'b1));
    wr(ADDR_PORT_CONTROL, ctl(4'h0, 2'h1, 1'b0, 1'b1));
    repeat (10) @(posedge clk);
    rd(ADDR_PORT_CONTROL, v);
    chk("fault", v, ctl(4'h2, 2'h1, 1'b1, 1'b1));
    far_u.select_drv = 1'b1;
    // slave: disabled, then fill the two-entry buffer past full
    int_enable <= 1'b0;
    wr(ADDR_SERIAL_CFG, 8'h00);
    wr(ADDR_PORT_CONTROL, ctl(4'h0, 2'h1, 1'b0, 1'b0));
    far_u.master_xfer(8'h5a, r);
    rd(ADDR_PORT_CONTROL, v);
    chk("disabled", v, ctl(4'h0, 2'h1, 1'b1, 1'b0));
    wr(ADDR_PORT_CONTROL, ctl(4'h0, 2'h1, 1'b0, 1'b1));
    d = $urandom;
    wr(ADDR_SERIAL_DATA, d);
    rd(ADDR_PORT_CONTROL, v);
    chk("tx_full", v, ctl(4'h0, 2'h1, 1'b0, 1'b1));
    for (int i = 0; i < 3; i++) begin
      b[i] = $urandom;
      far_u.master_xfer(b[i], r);
      if (i == 0) chk("miso", r, d);
    end
    repeat (10) @(posedge clk);
    rd(ADDR_PORT_CONTROL, v);
    chk("overrun", v, ctl(4'h9, 2'h1, 1'b1, 1'b1));
    chk("irq_masked", {7'h0, irq_request}, 8'h00);
    rd(ADDR_SERIAL_DATA, v);
    chk("rx0", v, b[0]);
    rd(ADDR_SERIAL_DATA, v);
    chk("rx1", v, b[1]);
    rd(ADDR_SERIAL_CFG, v);
    chk("rx_empty", v & 8'h01, 8'h01);
    wrap_up();
  end
endmodule : test_spcl_control_status
bind spcl_control_status spcl_props props_u (.*);
